// File: core/fe_save_regs.svh
// Offsets, field positions, reset values and constants of the FE save block
`ifndef FE_SAVE_REGS_SVH
`define FE_SAVE_REGS_SVH

`define FES_OFF_PC      12'h000
`define FES_OFF_PSW     12'h004
`define FES_OFF_HSW     12'h008
`define FES_OFF_CTRL    12'h00C
`define FES_OFF_STAT    12'h010

`define FES_PSW_WMASK   32'h43F7_80FF
`define FES_PSW_RESET   32'h0000_0020
`define FES_HSW_RESET   32'h0000_0020
`define FES_MASK_LSB    20
`define FES_MASK_MSB    25
`define FES_CU2_BIT     18
`define FES_PC_BIT0     0
`define FES_CTRL_HVE    0
`define FES_CTRL_EPL    1
`define FES_CTRL_LAST   1

`define FES_RESP_OKAY   2'h0
`define FES_RESP_SLVERR 2'h2

`endif

// File: core/fe_save_pkg.sv
// Types shared by the FE save block
package fe_save_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] ret_pc;
    logic [31:0] status;
  } fe_capture_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } sysreg_load_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] status;
  } fe_restore_s;
endpackage : fe_save_pkg

// File: core/fe_status_filter.sv
// Masking of status save writes: reserved bits, coprocessor top bit, mask gate
`timescale 1ns/100ps
`default_nettype none
`include "fe_save_regs.svh"
module fe_status_filter
  import fe_save_pkg::*;
(
  // Raw value and gate
  input  wire logic [31:0] i_raw,
  input  wire logic        i_epl,
  // Cleaned value
  output logic      [31:0] o_clean
);
  always_comb
  begin
    o_clean = i_raw & `FES_PSW_WMASK;
    o_clean[`FES_CU2_BIT] = 1'b0;
    if (!i_epl)
    begin
      o_clean[`FES_MASK_MSB:`FES_MASK_LSB] = 6'h00;
    end
  end
endmodule : fe_status_filter
`default_nettype wire

// File: core/axil_slave_port.sv
// AXI4-Lite slave handshake: one write and one read at a time
`timescale 1ns/100ps
`default_nettype none
`include "fe_save_regs.svh"
module axil_slave_port
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // AXI4-Lite
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Register side
  output logic             o_wr_en,
  output logic [11:0]      o_wr_addr,
  output logic [31:0]      o_wr_data,
  output logic [3:0]       o_wr_strb,
  output logic             o_rd_en,
  output logic [11:0]      o_rd_addr
);
  logic        aw_ready_r;
  logic        w_ready_r;
  logic        ar_ready_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_take;
  logic        w_take;

  // Ready flags registered so the top's outputs come from flip-flops
  assign o_awready = aw_ready_r;
  assign o_wready  = w_ready_r;
  assign o_arready = ar_ready_r;
  assign aw_take   = i_awvalid && aw_ready_r;
  assign w_take    = i_wvalid && w_ready_r;
  assign o_rd_en   = i_arvalid && ar_ready_r;
  assign o_rd_addr = i_araddr;
  // Write lands once both halves are in hand; a half arriving now bypasses its latch
  assign o_wr_en   = (!aw_ready_r || aw_take) && (!w_ready_r || w_take) && !o_bvalid;
  assign o_wr_addr = aw_ready_r ? i_awaddr : aw_addr_r;
  assign o_wr_data = w_ready_r ? i_wdata : w_data_r;
  assign o_wr_strb = w_ready_r ? i_wstrb : w_strb_r;

  // Each half refused once taken, until the response is accepted
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || (o_bvalid && i_bready))
    begin
      aw_ready_r <= 1'b1;
      w_ready_r  <= 1'b1;
    end
    else
    begin
      if (aw_take)
        aw_ready_r <= 1'b0;
      if (w_take)
        w_ready_r <= 1'b0;
    end
  end

  // Address and data latched in either order
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (aw_take)
        aw_addr_r <= i_awaddr;
      if (w_take)
      begin
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || (o_rvalid && i_rready))
      ar_ready_r <= 1'b1;
    else if (o_rd_en)
      ar_ready_r <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_bvalid <= 1'b0;
    else if (o_wr_en)
      o_bvalid <= 1'b1;
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_rvalid <= 1'b0;
    else if (o_rd_en)
      o_rvalid <= 1'b1;
    else if (i_rready)
      o_rvalid <= 1'b0;
  end
endmodule : axil_slave_port
`default_nettype wire

// File: core/host_fe_exception_save.sv
// Host-mode FE exception save registers with AXI4-Lite access
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fe_save_regs.svh"
module host_fe_exception_save
  import fe_save_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_reset,
  // Core events
  input  wire fe_save_pkg::fe_capture_s  i_fe_capture,
  input  wire logic                      i_fe_return,
  input  wire fe_save_pkg::sysreg_load_s i_hsw_load,
  input  wire logic                      i_insn_retire,
  input  wire logic [31:0]               i_insn_pc,
  // Restore toward the core
  output fe_save_pkg::fe_restore_s       o_fe_restore,
  output logic [31:0]                    o_host_status_word,
  output logic                           o_hypervisor_enable,
  // AXI4-Lite
  input  wire logic [11:0]               i_awaddr,
  input  wire logic                      i_awvalid,
  output logic                           o_awready,
  input  wire logic [31:0]               i_wdata,
  input  wire logic [3:0]                i_wstrb,
  input  wire logic                      i_wvalid,
  output logic                           o_wready,
  output logic [1:0]                     o_bresp,
  output logic                           o_bvalid,
  input  wire logic                      i_bready,
  input  wire logic [11:0]               i_araddr,
  input  wire logic                      i_arvalid,
  output logic                           o_arready,
  output logic [31:0]                    o_rdata,
  output logic [1:0]                     o_rresp,
  output logic                           o_rvalid,
  input  wire logic                      i_rready
);
  import fe_save_pkg::*;

  logic [31:0] fe_return_pc_save_r;
  logic [31:0] fe_status_save_r;
  logic [31:0] host_status_word_r;
  logic        hypervisor_enable_r;
  logic        priority_level_enable_r;
  logic        last_retired_valid_r;
  logic [31:0] last_retired_pc_r;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        rd_en;
  logic [11:0] rd_addr;
  logic [31:0] wr_merged;
  logic [31:0] psw_wr_clean;
  logic [31:0] cap_clean;
  logic [31:0] psw_nxt;
  logic [31:0] rd_nxt;
  logic        wr_pc_hit;
  logic        wr_psw_hit;
  logic        wr_hsw_hit;
  logic        wr_ctrl_hit;
  logic        wr_ok;
  logic        rd_ok;
  logic        capture_take;

  axil_slave_port u_port (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr)
  );

  // Byte-lane merge against the current register
  function automatic logic [31:0] merge_lanes(input logic [31:0] cur, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = cur;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = nw[b*8 +: 8];
    end
    return res;
  endfunction : merge_lanes

  // Save registers are visible only while the hypervisor is enabled
  assign wr_pc_hit   = wr_en && hypervisor_enable_r && (wr_addr == `FES_OFF_PC);
  assign wr_psw_hit  = wr_en && hypervisor_enable_r && (wr_addr == `FES_OFF_PSW);
  assign wr_hsw_hit  = wr_en && (wr_addr == `FES_OFF_HSW);
  assign wr_ctrl_hit = wr_en && (wr_addr == `FES_OFF_CTRL);
  assign wr_ok       = wr_pc_hit || wr_psw_hit || wr_hsw_hit || wr_ctrl_hit;
  assign capture_take = i_fe_capture.valid && hypervisor_enable_r;

  always_comb
  begin
    wr_merged = 32'h0000_0000;
    unique case (wr_addr)
      `FES_OFF_PC:   wr_merged = merge_lanes(fe_return_pc_save_r, wr_data, wr_strb);
      `FES_OFF_PSW:  wr_merged = merge_lanes(fe_status_save_r, wr_data, wr_strb);
      `FES_OFF_HSW:  wr_merged = merge_lanes(host_status_word_r, wr_data, wr_strb);
      default:       wr_merged = merge_lanes(32'h0000_0000, wr_data, wr_strb);
    endcase
  end

  fe_status_filter u_wr_filter (
    .i_raw   (wr_merged),
    .i_epl   (priority_level_enable_r),
    .o_clean (psw_wr_clean)
  );

  fe_status_filter u_cap_filter (
    .i_raw   (i_fe_capture.status),
    .i_epl   (priority_level_enable_r),
    .o_clean (cap_clean)
  );

  // Tracks last completed instruction for the reset value
  always_ff @(posedge i_clk_sys)
  begin
    if (i_insn_retire)
      last_retired_pc_r <= i_insn_pc;
  end

  // Seen flag read at the first reset edge, then cleared
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      last_retired_valid_r <= 1'b0;
    else if (i_insn_retire)
      last_retired_valid_r <= 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      if (last_retired_valid_r)
        fe_return_pc_save_r <= last_retired_pc_r;
    end
    else if (capture_take)
      fe_return_pc_save_r <= i_fe_capture.ret_pc;
    else if (wr_pc_hit)
      fe_return_pc_save_r <= wr_merged;
  end

  always_comb
  begin
    psw_nxt = fe_status_save_r;
    if (capture_take)
      psw_nxt = cap_clean;
    else if (wr_psw_hit)
      psw_nxt = psw_wr_clean;
    if (!priority_level_enable_r)
      psw_nxt[`FES_MASK_MSB:`FES_MASK_LSB] = 6'h00;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      fe_status_save_r <= `FES_PSW_RESET;
    else
      fe_status_save_r <= psw_nxt;
  end

  // Host status word: load held from the next cycle and at o_host_status_word one cycle later; return restore wins over load
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      host_status_word_r <= `FES_HSW_RESET;
    else if (i_fe_return)
      host_status_word_r <= fe_status_save_r;
    else if (i_hsw_load.valid)
      host_status_word_r <= i_hsw_load.data;
    else if (wr_hsw_hit)
      host_status_word_r <= wr_merged;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      hypervisor_enable_r     <= 1'b0;
      priority_level_enable_r <= 1'b0;
    end
    else if (wr_ctrl_hit && wr_strb[0])
    begin
      hypervisor_enable_r     <= wr_data[`FES_CTRL_HVE];
      priority_level_enable_r <= wr_data[`FES_CTRL_EPL];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_fe_restore <= '0;
    else
    begin
      o_fe_restore.valid  <= i_fe_return;
      o_fe_restore.pc     <= {fe_return_pc_save_r[31:1], 1'b0};
      o_fe_restore.status <= fe_status_save_r;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_host_status_word  <= `FES_HSW_RESET;
      o_hypervisor_enable <= 1'b0;
    end
    else
    begin
      o_host_status_word  <= host_status_word_r;
      o_hypervisor_enable <= hypervisor_enable_r;
    end
  end

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_nxt = 32'h0000_0000;
    if (rd_addr == `FES_OFF_PC && hypervisor_enable_r)
      rd_nxt = fe_return_pc_save_r;
    else if (rd_addr == `FES_OFF_PSW && hypervisor_enable_r)
      rd_nxt = fe_status_save_r;
    else if (rd_addr == `FES_OFF_HSW)
      rd_nxt = host_status_word_r;
    else if (rd_addr == `FES_OFF_CTRL)
      rd_nxt = {30'h0, priority_level_enable_r, hypervisor_enable_r};
    else if (rd_addr == `FES_OFF_STAT)
      rd_nxt = {31'h0, last_retired_valid_r};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_rdata <= 32'h0000_0000;
      o_rresp <= `FES_RESP_OKAY;
    end
    else if (rd_en)
    begin
      o_rdata <= rd_nxt;
      o_rresp <= rd_ok ? `FES_RESP_OKAY : `FES_RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_bresp <= `FES_RESP_OKAY;
    else if (wr_en)
      o_bresp <= wr_ok ? `FES_RESP_OKAY : `FES_RESP_SLVERR;
  end

  property p_reset_pc;
    @(posedge i_clk_sys)
    i_reset && last_retired_valid_r |=> fe_return_pc_save_r == $past(last_retired_pc_r);
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("reset pc not kept");

  property p_capture_pc;
    @(posedge i_clk_sys) disable iff (i_reset)
    capture_take |=> fe_return_pc_save_r == $past(i_fe_capture.ret_pc);
  endproperty
  a_capture_pc: assert property (p_capture_pc) else $error("return pc not captured");

  property p_return_even;
    @(posedge i_clk_sys) disable iff (i_reset)
    i_fe_return |=> o_fe_restore.valid && !o_fe_restore.pc[0] && o_fe_restore.pc[31:1] == $past(fe_return_pc_save_r[31:1]);
  endproperty
  a_return_even: assert property (p_return_even) else $error("restore pc wrong or odd");

  property p_capture_fields;
    @(posedge i_clk_sys) disable iff (i_reset)
    capture_take |=> fe_status_save_r[30] == $past(i_fe_capture.status[30])
      && fe_status_save_r[17:15] == $past(i_fe_capture.status[17:15]);
  endproperty
  a_capture_fields: assert property (p_capture_fields) else $error("status fields not captured");

  property p_capture_flags;
    @(posedge i_clk_sys) disable iff (i_reset)
    capture_take |=> fe_status_save_r[7:0] == $past(i_fe_capture.status[7:0]);
  endproperty
  a_capture_flags: assert property (p_capture_flags) else $error("status flags not captured");

  property p_reserved_zero;
    @(posedge i_clk_sys) disable iff (i_reset)
    (fe_status_save_r & ~`FES_PSW_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

  property p_reset_value;
    @(posedge i_clk_sys)
    i_reset |=> fe_status_save_r == `FES_PSW_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("status save reset value wrong");

  sequence s_epl_low;
    !priority_level_enable_r ##1 !priority_level_enable_r;
  endsequence
  property p_mask_gated;
    @(posedge i_clk_sys) disable iff (i_reset)
    s_epl_low |-> fe_status_save_r[`FES_MASK_MSB:`FES_MASK_LSB] == 6'h00;
  endproperty
  a_mask_gated: assert property (p_mask_gated) else $error("mask nonzero while gated");

  property p_mask_forced;
    @(posedge i_clk_sys) disable iff (i_reset)
    $fell(priority_level_enable_r) |=> fe_status_save_r[`FES_MASK_MSB:`FES_MASK_LSB] == 6'h00;
  endproperty
  a_mask_forced: assert property (p_mask_forced) else $error("mask not forced to zero");

  property p_cu2_zero;
    @(posedge i_clk_sys) disable iff (i_reset)
    !fe_status_save_r[`FES_CU2_BIT];
  endproperty
  a_cu2_zero: assert property (p_cu2_zero) else $error("top coprocessor bit set");

  property p_restore_hsw;
    @(posedge i_clk_sys) disable iff (i_reset)
    i_fe_return |=> host_status_word_r == $past(fe_status_save_r) ##1 o_host_status_word == $past(fe_status_save_r, 2);
  endproperty
  a_restore_hsw: assert property (p_restore_hsw) else $error("status word not restored");
endmodule : host_fe_exception_save
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the host-mode FE exception save block
`timescale 1ns/100ps
`default_nettype none
`include "fe_save_regs.svh"
module tb_top;
  import fe_save_pkg::*;

  logic         i_clk_sys;
  logic         i_reset;
  fe_capture_s  i_fe_capture;
  logic         i_fe_return;
  sysreg_load_s i_hsw_load;
  logic         i_insn_retire;
  logic [31:0]  i_insn_pc;
  fe_restore_s  o_fe_restore;
  logic [31:0]  o_host_status_word;
  logic         o_hypervisor_enable;
  logic [11:0]  i_awaddr;
  logic         i_awvalid;
  logic         o_awready;
  logic [31:0]  i_wdata;
  logic [3:0]   i_wstrb;
  logic         i_wvalid;
  logic         o_wready;
  logic [1:0]   o_bresp;
  logic         o_bvalid;
  logic         i_bready;
  logic [11:0]  i_araddr;
  logic         i_arvalid;
  logic         o_arready;
  logic [31:0]  o_rdata;
  logic [1:0]   o_rresp;
  logic         o_rvalid;
  logic         i_rready;
  int           miscompares;
  int           n_compared;

  host_fe_exception_save i_host_fe_exception_save (
    .i_clk_sys, .i_reset, .i_fe_capture, .i_fe_return, .i_hsw_load, .i_insn_retire, .i_insn_pc,
    .o_fe_restore, .o_host_status_word, .o_hypervisor_enable,
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready
  );

  initial i_clk_sys = 1'b0;
  always #2.5 i_clk_sys = ~i_clk_sys;

  task final_report;
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Bounded wait: a hang ends the run as a failure
  task automatic guard(inout int n);
    n++;
    if (n > 100)
    begin
      miscompares++;
      $display("mismatch handshake expected answer seen none");
      final_report;
    end
  endtask : guard

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       aw_ok;
    logic       w_ok;
    logic       aw_now;
    logic       w_now;
    logic       got;
    logic [1:0] resp;
    int         n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(negedge i_clk_sys);
      aw_now = !aw_ok && (o_awready === 1'b1);
      w_now = !w_ok && (o_wready === 1'b1);
      @(posedge i_clk_sys);
      if (aw_now) i_awvalid <= 1'b0;
      if (w_now) i_wvalid <= 1'b0;
      aw_ok = aw_ok || aw_now;
      w_ok = w_ok || w_now;
      guard(n);
    end
    got = 1'b0;
    while (!got)
    begin
      @(negedge i_clk_sys);
      got = (o_bvalid === 1'b1);
      resp = o_bresp;
      @(posedge i_clk_sys);
      guard(n);
    end
    i_bready <= 1'b0;
    check("bresp", {30'h0, resp}, {30'h0, er});
  endtask : wr

  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic        ar_ok;
    logic        got;
    logic [31:0] data;
    logic [1:0]  resp;
    int          n;
    ar_ok = 1'b0;
    got = 1'b0;
    n = 0;
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (!ar_ok)
    begin
      @(negedge i_clk_sys);
      ar_ok = (o_arready === 1'b1);
      @(posedge i_clk_sys);
      guard(n);
    end
    i_arvalid <= 1'b0;
    while (!got)
    begin
      @(negedge i_clk_sys);
      got = (o_rvalid === 1'b1);
      data = o_rdata;
      resp = o_rresp;
      @(posedge i_clk_sys);
      guard(n);
    end
    i_rready <= 1'b0;
    check(name, data, exp);
    check("rresp", {30'h0, resp}, {30'h0, er});
  endtask : rd

  task automatic capture(input logic [31:0] pc, input logic [31:0] st);
    @(posedge i_clk_sys);
    i_fe_capture <= '{valid: 1'b1, ret_pc: pc, status: st};
    @(posedge i_clk_sys);
    i_fe_capture.valid <= 1'b0;
  endtask : capture

  initial
  begin
    miscompares = 0;
    n_compared = 0;
    i_reset = 1'b1;
    i_fe_capture = '0;
    i_fe_return = 1'b0;
    i_hsw_load = '0;
    i_insn_retire = 1'b0;
    i_insn_pc = 32'h0000_0000;
    i_awaddr = 12'h000;
    i_awvalid = 1'b0;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'h0;
    i_wvalid = 1'b0;
    i_bready = 1'b0;
    i_araddr = 12'h000;
    i_arvalid = 1'b0;
    i_rready = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    check("host_status_word", o_host_status_word, `FES_HSW_RESET);
    rd("psw_hve_off", `FES_OFF_PSW, 32'h0000_0000, `FES_RESP_SLVERR);
    rd("unmapped", 12'h020, 32'h0000_0000, `FES_RESP_SLVERR);
    wr(12'h020, 32'hFFFF_FFFF, `FES_RESP_SLVERR);
    wr(`FES_OFF_CTRL, 32'h0000_0003, `FES_RESP_OKAY);
    rd("ctrl", `FES_OFF_CTRL, 32'h0000_0003, `FES_RESP_OKAY);
    check("hve", {31'h0, o_hypervisor_enable}, 32'h0000_0001);
    rd("psw_reset", `FES_OFF_PSW, `FES_PSW_RESET, `FES_RESP_OKAY);
    wr(`FES_OFF_PSW, 32'hFFFF_FFFF, `FES_RESP_OKAY);
    rd("psw_ones", `FES_OFF_PSW, 32'h43F3_80FF, `FES_RESP_OKAY);
    wr(`FES_OFF_CTRL, 32'h0000_0001, `FES_RESP_OKAY);
    rd("psw_epl_clr", `FES_OFF_PSW, 32'h4003_80FF, `FES_RESP_OKAY);
    wr(`FES_OFF_PSW, 32'h03F0_0000, `FES_RESP_OKAY);
    rd("psw_mask_gate", `FES_OFF_PSW, 32'h0000_0000, `FES_RESP_OKAY);
    // Capture with the mask gate closed, then open
    capture(32'h1234_5678, 32'hFFFF_FFFF);
    rd("pc_cap", `FES_OFF_PC, 32'h1234_5678, `FES_RESP_OKAY);
    rd("psw_cap_gated", `FES_OFF_PSW, 32'h4003_80FF, `FES_RESP_OKAY);
    wr(`FES_OFF_CTRL, 32'h0000_0003, `FES_RESP_OKAY);
    capture(32'h0000_2468, 32'h5A5A_A5A5);
    rd("psw_cap", `FES_OFF_PSW, 32'h4252_80A5, `FES_RESP_OKAY);
    rd("pc_cap2", `FES_OFF_PC, 32'h0000_2468, `FES_RESP_OKAY);
    // Capture must be ignored while the hypervisor is off
    wr(`FES_OFF_CTRL, 32'h0000_0002, `FES_RESP_OKAY);
    capture(32'hDEAD_0000, 32'h0000_0000);
    wr(`FES_OFF_CTRL, 32'h0000_0003, `FES_RESP_OKAY);
    rd("pc_kept", `FES_OFF_PC, 32'h0000_2468, `FES_RESP_OKAY);
    wr(`FES_OFF_PC, 32'h0000_3000, `FES_RESP_OKAY);
    rd("pc_even", `FES_OFF_PC, 32'h0000_3000, `FES_RESP_OKAY);
    // Return with an odd saved address
    wr(`FES_OFF_PC, 32'h0000_1001, `FES_RESP_OKAY);
    @(posedge i_clk_sys);
    i_fe_return <= 1'b1;
    @(posedge i_clk_sys);
    i_fe_return <= 1'b0;
    #1;
    check("restore_valid", {31'h0, o_fe_restore.valid}, 32'h0000_0001);
    check("restore_pc", o_fe_restore.pc, 32'h0000_1000);
    check("restore_status", o_fe_restore.status, 32'h4252_80A5);
    @(posedge i_clk_sys);
    #1;
    check("restore_pulse", {31'h0, o_fe_restore.valid}, 32'h0000_0000);
    check("hsw_restored", o_host_status_word, 32'h4252_80A5);
    // System-register load of the host status word
    @(posedge i_clk_sys);
    i_hsw_load <= '{valid: 1'b1, data: 32'h0000_001F};
    @(posedge i_clk_sys);
    i_hsw_load.valid <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    check("hsw_load", o_host_status_word, 32'h0000_001F);
    rd("hsw_reg", `FES_OFF_HSW, 32'h0000_001F, `FES_RESP_OKAY);
    // Last retired address survives a reset
    @(posedge i_clk_sys);
    i_insn_retire <= 1'b1;
    i_insn_pc <= 32'h0000_ABC0;
    @(posedge i_clk_sys);
    i_insn_retire <= 1'b0;
    rd("stat_seen", `FES_OFF_STAT, 32'h0000_0001, `FES_RESP_OKAY);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    wr(`FES_OFF_CTRL, 32'h0000_0001, `FES_RESP_OKAY);
    rd("pc_after_reset", `FES_OFF_PC, 32'h0000_ABC0, `FES_RESP_OKAY);
    rd("psw_after_reset", `FES_OFF_PSW, `FES_PSW_RESET, `FES_RESP_OKAY);
    rd("stat_cleared", `FES_OFF_STAT, 32'h0000_0000, `FES_RESP_OKAY);
    final_report;
  end
endmodule : tb_top
`default_nettype wire
